//--- logic/mrs_modbus_slave.sv
/*
  Modbus RTU slave for a humidity and temperature sensor: receiver, frame
  check, register map and transmitter with driver enable.
  Assumes rs485_rx comes from a transceiver pin and meas is on ref_clk.
*/
module mrs_modbus_slave #(
  parameter logic [7:0]   FIRMWARE_MAJOR = 8'h01,
  parameter logic [7:0]   FIRMWARE_MINOR = 8'h00,
  parameter logic [4:0]   MAX_READ_REGS  = 5'h10,
  parameter int           CLK_HZ         = mrs_pkg::CLK_HZ,
  parameter logic [127:0] SERIAL_TEXT    = "0000000000000000",
  parameter logic [127:0] LABEL_TEXT     = "HUMIDITY SENSOR "
) (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              rs485_rx,
  input  wire mrs_pkg::mrs_meas_t meas,
  output logic                   rs485_tx,
  output logic                   rs485_de
);

  typedef enum {TX_IDLE, TX_FETCH, TX_LOAD, TX_BITS} mrs_tx_state_t;

  mrs_pkg::mrs_serial_cfg_t cfg_r;
  mrs_pkg::mrs_serial_cfg_t pend_cfg_r;
  mrs_pkg::mrs_meas_t       snap_r;
  mrs_tx_state_t            tx_state_r;
  logic [7:0]  slave_addr_r;
  logic [7:0]  pend_addr_r;
  logic        pend_valid_r;
  logic        rx_s1_r, rx_s2_r, rx_s3_r, rx_lvl_r, rx_prev_r;
  logic [15:0] cur_div;
  logic [15:0] div_cnt_r;
  logic        baud_tick_r;
  logic        rx_busy_r;
  logic [15:0] rx_cnt_r;
  logic [3:0]  rx_bit_r;
  logic [7:0]  rx_sh_r;
  logic        rx_par_r;
  logic        char_done_r;
  logic        char_err_r;
  logic [7:0]  rq_buf_r [8];
  logic [3:0]  rq_cnt_r;
  logic        rq_bad_r;
  logic [15:0] rq_crc_r;
  logic [5:0]  gap_r;
  logic        frame_end_r;
  logic [7:0]  fc;
  logic [15:0] start_addr, qty, last_addr;
  logic        frame_ok, rd_ok, wr_addr_ok, wr_set_ok, accept;
  logic [5:0]  tx_pos_r, tx_len_r;
  logic        tx_read_r;
  logic [15:0] tx_start_r, tx_crc_r;
  logic [11:0] tx_sh_r;
  logic [3:0]  tx_left_r;
  logic        tx_r, de_r;
  logic [15:0] reg_addr, reg_word, rom_q;
  logic [3:0]  rom_addr;
  logic [7:0]  tx_byte;
  logic        tx_par;
  logic        tx_last;

  assign cur_div = mrs_pkg::baud_div(cfg_r.baud_sel, CLK_HZ);

  // ==========================================================================
  // Pin synchroniser and bit-rate enable
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_s1_r  <= 1'b1;
      rx_s2_r  <= 1'b1;
      rx_s3_r  <= 1'b1;
      rx_lvl_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end
    else
    begin
      rx_s1_r <= rs485_rx;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r)
        rx_lvl_r <= rx_s3_r;
      rx_prev_r <= rx_lvl_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_cnt_r   <= 16'h0000;
      baud_tick_r <= 1'b0;
    end
    else if (div_cnt_r >= cur_div - 16'h0001)
    begin
      div_cnt_r   <= 16'h0000;
      baud_tick_r <= 1'b1;
    end
    else
    begin
      div_cnt_r   <= div_cnt_r + 16'h0001;
      baud_tick_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Character receiver, sampling mid-bit
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_busy_r   <= 1'b0;
      rx_cnt_r    <= 16'h0000;
      rx_bit_r    <= 4'h0;
      rx_sh_r     <= 8'h00;
      rx_par_r    <= 1'b0;
      char_done_r <= 1'b0;
      char_err_r  <= 1'b0;
    end
    else
    begin
      char_done_r <= 1'b0;
      if (!rx_busy_r)
      begin
        if (rx_prev_r && !rx_lvl_r)
        begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= cur_div >> 1;
          rx_bit_r  <= 4'h0;
        end
      end
      else if (rx_cnt_r != 16'h0000)
        rx_cnt_r <= rx_cnt_r - 16'h0001;
      else
      begin
        rx_cnt_r <= cur_div - 16'h0001;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0)
          rx_busy_r <= !rx_lvl_r;
        else if (rx_bit_r <= 4'h8)
          rx_sh_r <= {rx_lvl_r, rx_sh_r[7:1]};
        else if (rx_bit_r == 4'h9 && cfg_r.parity != mrs_pkg::MRS_PAR_NONE)
          rx_par_r <= rx_lvl_r;
        else
        begin
          // A second stop bit, when set, simply reads as idle line.
          rx_busy_r   <= 1'b0;
          char_done_r <= 1'b1;
          char_err_r  <= !rx_lvl_r || (cfg_r.parity != mrs_pkg::MRS_PAR_NONE &&
                         ((^rx_sh_r) ^ rx_par_r) != (cfg_r.parity == mrs_pkg::MRS_PAR_ODD));
        end
      end
    end
  end

  // ==========================================================================
  // Frame collection, CRC and silent-gap detection
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rq_cnt_r    <= 4'h0;
      rq_bad_r    <= 1'b0;
      rq_crc_r    <= mrs_pkg::CRC_INIT;
      gap_r       <= 6'h00;
      frame_end_r <= 1'b0;
      for (int i = 0; i < 8; i++)
        rq_buf_r[i] <= 8'h00;
    end
    else
    begin
      frame_end_r <= 1'b0;
      if (rx_busy_r || !rx_lvl_r)
        gap_r <= 6'h00;
      else if (baud_tick_r && gap_r != mrs_pkg::GAP_BITS)
      begin
        gap_r <= gap_r + 6'h01;
        frame_end_r <= (gap_r == mrs_pkg::GAP_BITS - 6'h01) && (rq_cnt_r != 4'h0);
      end
      // Our own echo on a half-duplex pair must not become a request.
      if (de_r || frame_end_r)
      begin
        rq_cnt_r <= 4'h0;
        rq_bad_r <= 1'b0;
        rq_crc_r <= mrs_pkg::CRC_INIT;
      end
      else if (char_done_r)
      begin
        if (rq_cnt_r < mrs_pkg::REQ_BYTES)
          rq_buf_r[rq_cnt_r[2:0]] <= rx_sh_r;
        if (rq_cnt_r <= mrs_pkg::REQ_BYTES)
          rq_cnt_r <= rq_cnt_r + 4'h1;
        rq_crc_r <= mrs_pkg::crc16_byte(rq_crc_r, rx_sh_r);
        rq_bad_r <= rq_bad_r || char_err_r;
      end
    end
  end

  // ==========================================================================
  // Request decode
  assign fc         = rq_buf_r[1];
  assign start_addr = {rq_buf_r[2], rq_buf_r[3]};
  assign qty        = {rq_buf_r[4], rq_buf_r[5]};
  assign last_addr  = start_addr + qty - 16'h0001;
  assign frame_ok   = rq_cnt_r == mrs_pkg::REQ_BYTES && !rq_bad_r &&
                      rq_crc_r == 16'h0000 && rq_buf_r[0] == slave_addr_r;
  assign rd_ok      = (fc == mrs_pkg::FC_READ_HOLD || fc == mrs_pkg::FC_READ_INPUT) &&
                      qty != 16'h0000 && qty <= {11'h000, MAX_READ_REGS} &&
                      mrs_pkg::reg_block(start_addr, fc) != 2'h0 &&
                      mrs_pkg::reg_block(start_addr, fc) == mrs_pkg::reg_block(last_addr, fc);
  assign wr_addr_ok = fc == mrs_pkg::FC_WRITE_ONE && start_addr == mrs_pkg::PA_SLAVE_ADDR &&
                      qty[15:8] == 8'h00 && qty[7:0] >= mrs_pkg::SLAVE_ADDR_MIN &&
                      qty[7:0] <= mrs_pkg::SLAVE_ADDR_MAX;
  // Only serial fields exist in the settings word; the unit cannot be reached.
  assign wr_set_ok  = fc == mrs_pkg::FC_WRITE_ONE && start_addr == mrs_pkg::PA_SERIAL_SET &&
                      qty[15:mrs_pkg::SET_USED] == '0 &&
                      qty[mrs_pkg::SET_BAUD_LSB +: 3] <= mrs_pkg::BAUD_SEL_MAX &&
                      qty[mrs_pkg::SET_PAR_LSB +: 2] != 2'(mrs_pkg::MRS_PAR_BAD);
  assign accept     = frame_end_r && frame_ok && (rd_ok || wr_addr_ok || wr_set_ok);

  // ==========================================================================
  // Settings and measurement snapshot
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_r        <= mrs_pkg::CFG_RST;
      pend_cfg_r   <= mrs_pkg::CFG_RST;
      slave_addr_r <= mrs_pkg::SLAVE_ADDR_RST;
      pend_addr_r  <= mrs_pkg::SLAVE_ADDR_RST;
      pend_valid_r <= 1'b0;
    end
    else if (accept && wr_addr_ok)
    begin
      pend_addr_r  <= qty[7:0];
      pend_cfg_r   <= cfg_r;
      pend_valid_r <= 1'b1;
    end
    else if (accept && wr_set_ok)
    begin
      pend_addr_r  <= slave_addr_r;
      pend_cfg_r   <= '{baud_sel: qty[mrs_pkg::SET_BAUD_LSB +: 3],
                        parity:   mrs_pkg::mrs_parity_t'(qty[mrs_pkg::SET_PAR_LSB +: 2]),
                        two_stop: qty[mrs_pkg::SET_STOP_BIT]};
      pend_valid_r <= 1'b1;
    end
    else if (pend_valid_r && tx_state_r == TX_IDLE)
    begin
      // The echo goes out first at the old settings, then they switch.
      cfg_r        <= pend_cfg_r;
      slave_addr_r <= pend_addr_r;
      pend_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      snap_r <= '0;
    else if (accept && rd_ok)
      snap_r <= meas;
  end

  // ==========================================================================
  // Reply byte source
  assign reg_addr = tx_start_r + {11'h000, 5'((tx_pos_r - mrs_pkg::HDR_BYTES) >> 1)};
  assign rom_addr = (reg_addr <= mrs_pkg::PA_SERIAL_LAST) ? reg_addr[3:0] :
                    4'(reg_addr - mrs_pkg::PA_LABEL_TEXT + mrs_pkg::ROM_LABEL_BASE);

  mrs_id_rom #(
    .SERIAL_TEXT (SERIAL_TEXT),
    .LABEL_TEXT  (LABEL_TEXT)
  ) u_id_rom (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .addr    (rom_addr),
    .rd_data (rom_q)
  );

  always_comb
  begin
    case (reg_addr)
      mrs_pkg::PA_FIRMWARE:   reg_word = {FIRMWARE_MAJOR, FIRMWARE_MINOR};
      mrs_pkg::PA_TEMP_FLOAT: reg_word = snap_r.temp_float[15:0];
      mrs_pkg::PA_TEMP_FL_HI: reg_word = snap_r.temp_float[31:16];
      mrs_pkg::PA_HUM_FLOAT:  reg_word = snap_r.hum_float[15:0];
      mrs_pkg::PA_HUM_FL_HI:  reg_word = snap_r.hum_float[31:16];
      mrs_pkg::PA_TEMP_INT:   reg_word = snap_r.temp_int;
      mrs_pkg::PA_HUM_INT:    reg_word = snap_r.hum_int;
      default:                reg_word = rom_q;
    endcase
  end

  assign tx_last = tx_pos_r >= tx_len_r - mrs_pkg::CRC_BYTES;

  always_comb
  begin
    if (!tx_read_r)
      tx_byte = rq_buf_r[tx_pos_r[2:0]];
    else if (tx_pos_r == 6'h00)
      tx_byte = slave_addr_r;
    else if (tx_pos_r == 6'h01)
      tx_byte = rq_buf_r[1];
    else if (tx_pos_r == 6'h02)
      tx_byte = 8'(tx_len_r - mrs_pkg::HDR_BYTES - mrs_pkg::CRC_BYTES);
    else if (tx_last)
      tx_byte = (tx_pos_r == tx_len_r - mrs_pkg::CRC_BYTES) ? tx_crc_r[7:0] : tx_crc_r[15:8];
    else
      tx_byte = tx_pos_r[0] ? reg_word[15:8] : reg_word[7:0];
    tx_par = (^tx_byte) ^ (cfg_r.parity == mrs_pkg::MRS_PAR_ODD);
  end

  // ==========================================================================
  // Transmitter and driver enable
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_state_r <= TX_IDLE;
      tx_pos_r   <= 6'h00;
      tx_len_r   <= 6'h00;
      tx_read_r  <= 1'b0;
      tx_start_r <= 16'h0000;
      tx_crc_r   <= mrs_pkg::CRC_INIT;
      tx_sh_r    <= 12'hFFF;
      tx_left_r  <= 4'h0;
      tx_r       <= 1'b1;
      de_r       <= 1'b0;
    end
    else
    begin
      case (tx_state_r)
        TX_IDLE:
          if (accept)
          begin
            tx_state_r <= TX_FETCH;
            de_r       <= 1'b1;
            tx_pos_r   <= 6'h00;
            tx_crc_r   <= mrs_pkg::CRC_INIT;
            tx_read_r  <= rd_ok;
            tx_start_r <= start_addr;
            tx_len_r   <= rd_ok ? 6'(mrs_pkg::HDR_BYTES + mrs_pkg::CRC_BYTES + 2 * qty[4:0]) :
                          6'(mrs_pkg::REQ_BYTES);
          end
        TX_FETCH:
          tx_state_r <= TX_LOAD;
        TX_LOAD:
          if (baud_tick_r)
          begin
            tx_r       <= 1'b0;
            tx_sh_r    <= {2'b11, (cfg_r.parity == mrs_pkg::MRS_PAR_NONE) ? 1'b1 : tx_par,
                           tx_byte, 1'b0} >> 1;
            tx_left_r  <= 4'(9 + (cfg_r.parity != mrs_pkg::MRS_PAR_NONE) + cfg_r.two_stop);
            if (!tx_last)
              tx_crc_r <= mrs_pkg::crc16_byte(tx_crc_r, tx_byte);
            tx_state_r <= TX_BITS;
          end
        TX_BITS:
          if (baud_tick_r)
          begin
            if (tx_left_r != 4'h0)
            begin
              tx_r      <= tx_sh_r[0];
              tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
              tx_left_r <= tx_left_r - 4'h1;
            end
            else if (tx_pos_r + 6'h01 == tx_len_r)
            begin
              tx_state_r <= TX_IDLE;
              de_r       <= 1'b0;
            end
            else
            begin
              tx_pos_r   <= tx_pos_r + 6'h01;
              tx_state_r <= TX_FETCH;
            end
          end
        default:
          tx_state_r <= TX_IDLE;
      endcase
    end
  end

  assign rs485_tx = tx_r;
  assign rs485_de = de_r;

endmodule

//--- logic/mrs_pkg.sv
/*
  Constants, types and helper functions for the Modbus RTU sensor slave.
  Assumes a 100 MHz ref_clk and one RS485 half-duplex transceiver outside.
*/
// Contract
// - Baud selectable 9600 to 115200, default 9600.
// - Function 0x06 writes slave address or serial settings.
// - Slave address defaults 245, accepts 1..247.
// - Addresses 0..7 return serial number ASCII text.
// - Address 8 returns firmware major/minor bytes.
// - Sensor name text starts at address 9.
// - Identification registers readable by 0x03 or 0x04.
// - Float halves come from one coherent snapshot.
// - Floats at 0x19 and 0x1B, read by 0x03.
// - Scaled integers at 0x12C and 0x12D, times 100.
// - Temperature unit fixed, not writable over bus.
// - First float register low mantissa, second sign/exponent.
// - Request and reply byte layout per Modbus RTU.
package mrs_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ   = 100_000_000;
  localparam int BAUD_DEF = 9600;
  // Frame end after 3.5 characters of 11 bits of idle line, rounded up.
  localparam logic [5:0] GAP_BITS = 6'h27;

  // ==========================================================================
  // Protocol codes and addresses
  localparam logic [7:0]  FC_READ_HOLD   = 8'h03;
  localparam logic [7:0]  FC_READ_INPUT  = 8'h04;
  localparam logic [7:0]  FC_WRITE_ONE   = 8'h06;
  localparam logic [15:0] PA_SLAVE_ADDR  = 16'h0000;
  localparam logic [15:0] PA_SERIAL_SET  = 16'h0001;
  localparam logic [15:0] PA_SERIAL_LAST = 16'h0007;
  localparam logic [15:0] PA_FIRMWARE    = 16'h0008;
  localparam logic [15:0] PA_LABEL_TEXT  = 16'h0009;
  localparam logic [15:0] PA_LABEL_LAST  = 16'h0010;
  localparam logic [15:0] PA_TEMP_FLOAT  = 16'h0019;
  localparam logic [15:0] PA_TEMP_FL_HI  = 16'h001A;
  localparam logic [15:0] PA_HUM_FLOAT   = 16'h001B;
  localparam logic [15:0] PA_HUM_FL_HI   = 16'h001C;
  localparam logic [15:0] PA_TEMP_INT    = 16'h012C;
  localparam logic [15:0] PA_HUM_INT     = 16'h012D;
  localparam logic [15:0] ROM_LABEL_BASE = 16'h0008;

  localparam logic [7:0] SLAVE_ADDR_RST = 8'hF5;
  localparam logic [7:0] SLAVE_ADDR_MIN = 8'h01;
  localparam logic [7:0] SLAVE_ADDR_MAX = 8'hF7;

  // ==========================================================================
  // Frame layout
  localparam logic [3:0] REQ_BYTES = 4'h8;
  localparam logic [5:0] HDR_BYTES = 6'h03;
  localparam logic [5:0] CRC_BYTES = 6'h02;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // ==========================================================================
  // Serial settings word: baud select, parity, two stop bits
  localparam int SET_BAUD_LSB = 0;
  localparam int SET_PAR_LSB  = 3;
  localparam int SET_STOP_BIT = 5;
  localparam int SET_USED     = 6;
  localparam logic [2:0] BAUD_SEL_MAX = 3'h5;

  typedef enum logic [1:0] {MRS_PAR_NONE, MRS_PAR_ODD, MRS_PAR_EVEN, MRS_PAR_BAD} mrs_parity_t;

  typedef struct packed {
    logic [2:0]  baud_sel;
    mrs_parity_t parity;
    logic        two_stop;
  } mrs_serial_cfg_t;

  localparam mrs_serial_cfg_t CFG_RST = '{baud_sel: 3'h0, parity: MRS_PAR_EVEN, two_stop: 1'b0};

  typedef struct packed {
    logic [31:0] temp_float;
    logic [31:0] hum_float;
    logic [15:0] temp_int;
    logic [15:0] hum_int;
  } mrs_meas_t;

  // ==========================================================================
  // Functions
  function automatic logic [15:0] baud_div(input logic [2:0] sel, input int clk_hz);
    case (sel)
      3'h1:    return 16'(clk_hz / 19200);
      3'h2:    return 16'(clk_hz / 38400);
      3'h3:    return 16'(clk_hz / 57600);
      3'h4:    return 16'(clk_hz / 76800);
      3'h5:    return 16'(clk_hz / 115200);
      default: return 16'(clk_hz / BAUD_DEF);
    endcase
  endfunction

  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // Register block of an address; reads must stay inside one block.
  function automatic logic [1:0] reg_block(input logic [15:0] a, input logic [7:0] fc);
    if (a <= PA_LABEL_LAST)
      return 2'h1;
    if (fc != FC_READ_HOLD)
      return 2'h0;
    if (a >= PA_TEMP_FLOAT && a <= PA_HUM_FL_HI)
      return 2'h2;
    if (a == PA_TEMP_INT || a == PA_HUM_INT)
      return 2'h3;
    return 2'h0;
  endfunction

endpackage

//--- logic/mrs_id_rom.sv
/*
  Identification text memory: serial number words then sensor name words.
  Assumes the reader presents the address one cycle before it uses the data.
*/
module mrs_id_rom #(
  parameter logic [127:0] SERIAL_TEXT = "0000000000000000",
  parameter logic [127:0] LABEL_TEXT  = "HUMIDITY SENSOR "
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  addr,
  output logic      [15:0] rd_data
);

  logic [15:0] rd_data_r;

  // ==========================================================================
  // Registered read, first character in the high byte
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rd_data_r <= 16'h0000;
    else if (addr[3])
      rd_data_r <= LABEL_TEXT[127 - 16 * addr[2:0] -: 16];
    else
      rd_data_r <= SERIAL_TEXT[127 - 16 * addr[2:0] -: 16];
  end

  assign rd_data = rd_data_r;

endmodule

//--- testbench/mrs_modbus_slave_properties.sv
/*
  Port-level properties of the sensor slave: reply timing and line levels.
  Assumes ref_clk runs at CLK_HZ and baud rates no faster than 115200.
*/
module mrs_modbus_slave_properties #(
  parameter int CLK_HZ = mrs_pkg::CLK_HZ
) (
  input wire logic               ref_clk,
  input wire logic               rstn,
  input wire logic               rs485_rx,
  input wire mrs_pkg::mrs_meas_t meas,
  input wire logic               rs485_tx,
  input wire logic               rs485_de
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bounds follow the bit time of the slowest and fastest baud at CLK_HZ.
  localparam int          BIT_SLOW = CLK_HZ / 9600;
  localparam int          BIT_FAST = CLK_HZ / 115200;
  localparam logic [31:0] LEAD_MAX = 32'(BIT_SLOW + 14);
  localparam logic [31:0] GAP_MIN  = 32'(38 * BIT_FAST);
  localparam logic [31:0] SPAN_MIN = 32'(70 * BIT_FAST);
  localparam logic [31:0] RUN_MIN  = 32'(BIT_FAST - 2);

  // ==========================================================================
  // Helper counters
  logic [31:0] lead_cnt_r;
  logic [31:0] idle_cnt_r;
  logic [31:0] de_cnt_r;
  logic [31:0] run_cnt_r;
  logic        started_r;
  logic        tx_q_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lead_cnt_r <= '0;
      idle_cnt_r <= '0;
      de_cnt_r   <= '0;
      run_cnt_r  <= '0;
      started_r  <= 1'b0;
      tx_q_r     <= 1'b1;
    end
    else
    begin
      lead_cnt_r <= (rs485_de && rs485_tx && !started_r) ? lead_cnt_r + 1 : '0;
      started_r  <= rs485_de && (started_r || !rs485_tx);
      idle_cnt_r <= rs485_rx ? idle_cnt_r + 1 : '0;
      de_cnt_r   <= rs485_de ? de_cnt_r + 1 : '0;
      run_cnt_r  <= (rs485_tx != tx_q_r) ? '0 : run_cnt_r + 1;
      tx_q_r     <= rs485_tx;
    end
  end

  // ==========================================================================
  // Properties
  sequence s_lead_mark;
    rs485_tx [*2];
  endsequence

  a_reset_quiet: assert property ($rose(rstn) |-> rs485_tx && !rs485_de)
    else $error("line not quiet after reset");
  a_idle_high: assert property (!rs485_de |-> rs485_tx)
    else $error("transmit line low while driver off");
  a_lead_mark: assert property ($rose(rs485_de) |-> s_lead_mark)
    else $error("start bit together with driver enable");
  a_start_bound: assert property (lead_cnt_r <= LEAD_MAX)
    else $error("start bit late after driver enable");
  a_gap_first: assert property ($rose(rs485_de) |-> idle_cnt_r >= GAP_MIN)
    else $error("reply without frame gap");
  a_reply_span: assert property ($fell(rs485_de) |-> de_cnt_r >= SPAN_MIN)
    else $error("reply shorter than any valid frame");
  a_bit_width: assert property (rs485_de && $changed(rs485_tx) |-> run_cnt_r >= RUN_MIN)
    else $error("bit shorter than fastest baud");
  a_stop_end: assert property ($fell(rs485_de) |-> $past(rs485_tx) && rs485_tx)
    else $error("driver released inside a character");
endmodule

bind mrs_modbus_slave mrs_modbus_slave_properties #(.CLK_HZ(CLK_HZ)) u_props (
  .ref_clk  (ref_clk),
  .rstn     (rstn),
  .rs485_rx (rs485_rx),
  .meas     (meas),
  .rs485_tx (rs485_tx),
  .rs485_de (rs485_de)
);

//--- testbench/mrs_master_model.sv
/*
  Bus master model: sends request frames and collects the replies.
  Assumes the slave's pins and the bench's ref_clk; drives on falling edges.
*/
module mrs_master_model (
  input  wire logic ref_clk,
  output logic      rx_line,
  input  wire logic tx_line,
  input  wire logic de_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bit_clks = 10416;
  logic [1:0] par      = 2'h2;
  logic       two_stop = 1'b0;
  logic [7:0] reply[$];
  logic       par_ok;

  initial rx_line = 1'b1;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    return r;
  endfunction

  task automatic hold(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // A bad flag corrupts the CRC so that the frame must be dropped.
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) c = crc_step(c, f[i]);
    f.push_back(c[7:0] ^ {7'h00, bad});
    f.push_back(c[15:8]);
    foreach (f[i])
    begin
      rx_line = 1'b0;
      hold(bit_clks);
      for (int k = 0; k < 8; k++)
      begin
        rx_line = f[i][k];
        hold(bit_clks);
      end
      if (par != 2'h0)
      begin
        rx_line = (par == 2'h1) ^ (^f[i]);
        hold(bit_clks);
      end
      rx_line = 1'b1;
      hold(two_stop ? 2 * bit_clks : bit_clks);
    end
  endtask

  // Returns at the fall of the driver enable, or after 45 bit times with no driver enable, so the next frame never overlaps.
  task automatic collect();
    int         k;
    logic [7:0] v;
    reply.delete();
    par_ok = 1'b1;
    k = 0;
    while (!de_line && k < 45 * bit_clks)
    begin
      hold(1);
      k++;
    end
    while (de_line)
    begin
      k = 0;
      while (tx_line && de_line && k < 3 * bit_clks)
      begin
        hold(1);
        k++;
      end
      if (tx_line)
        break;
      hold(bit_clks / 2);
      for (int b = 0; b < 8; b++)
      begin
        hold(bit_clks);
        v[b] = tx_line;
      end
      if (par != 2'h0)
      begin
        hold(bit_clks);
        par_ok &= (tx_line === ((par == 2'h1) ^ (^v)));
      end
      hold(bit_clks);
      reply.push_back(v);
    end
  endtask
endmodule

//--- testbench/mrs_modbus_slave_tb.sv
/*
  Self-checking bench for the sensor slave: register traffic over the bus.
  Assumes the master model and the bound property checker.
*/
module mrs_modbus_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] SER = "SN0123456789ABCD";
  localparam logic [127:0] LBL = "HUMID-TEMP PROBE";
  // A low nominal clock rate keeps each bit a few cycles long and the run brief.
  localparam int           TB_CLK_HZ = 1_152_000;
  logic               ref_clk    = 1'b0;
  logic               rstn       = 1'b0;
  logic               rs485_rx;
  logic               rs485_tx;
  logic               rs485_de;
  mrs_pkg::mrs_meas_t meas       = '{32'h41BA51F0, 32'h42480000, 16'h0919, 16'h1388};
  int                 num_errors = 0;
  int                 n_checks   = 0;
  logic [7:0]         e[$];
  logic [7:0]         nil[$];

  always #5 ref_clk = ~ref_clk;

  mrs_modbus_slave #(.CLK_HZ(TB_CLK_HZ), .SERIAL_TEXT(SER), .LABEL_TEXT(LBL)) DUT (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .rs485_rx (rs485_rx),
    .meas     (meas),
    .rs485_tx (rs485_tx),
    .rs485_de (rs485_de)
  );

  mrs_master_model master (
    .ref_clk (ref_clk),
    .rx_line (rs485_rx),
    .tx_line (rs485_tx),
    .de_line (rs485_de)
  );

  // ==========================================================================
  // Tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // An empty expectation means the request must be ignored.
  task automatic xact(input logic [7:0] req[$], input logic [7:0] exp[$], input logic bad);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (exp[i]) c = master.crc_step(c, exp[i]);
    if (exp.size() > 0)
    begin
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    master.send(req, bad);
    master.collect();
    check("reply length", 16'(master.reply.size()), 16'(exp.size()));
    foreach (exp[i])
      check("reply byte", {8'h00, master.reply[i]}, {8'h00, exp[i]});
    check("reply parity", {15'h0000, master.par_ok}, 16'h0001);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] r, input logic [15:0] v,
                    input logic ok);
    logic [7:0] q[$];
    q = '{a, 8'h06, r[15:8], r[7:0], v[15:8], v[7:0]};
    if (ok)
      xact(q, q, 1'b0);
    else
      xact(q, nil, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] fc, input logic [15:0] s,
                    input logic [7:0] n, input logic [7:0] d[$], input logic ok);
    logic [7:0] q[$];
    q = '{a, fc, s[15:8], s[7:0], 8'h00, n};
    d.push_front(8'(2 * n));
    d.push_front(fc);
    d.push_front(a);
    if (ok)
      xact(q, d, 1'b0);
    else
      xact(q, nil, 1'b0);
  endtask

  function automatic void load(input logic [127:0] t);
    e.delete();
    for (int i = 0; i < 16; i++)
      e.push_back(t[127 - 8 * i -: 8]);
  endfunction

  // ==========================================================================
  // Sequence
  initial
  begin
    repeat (90_000) @(posedge ref_clk);
    num_errors++;
    end_of_test();
  end

  initial
  begin
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    master.bit_clks = TB_CLK_HZ / 9600;
    master.hold(40);
    wr(8'hF5, 16'h0001, 16'h0015, 1'b1);
    master.bit_clks = TB_CLK_HZ / 115200;
    fork
      rd(8'hF5, 8'h03, 16'h0019, 8'h04, '{8'h51, 8'hF0, 8'h41, 8'hBA, 8'h00, 8'h00, 8'h42,
         8'h48}, 1'b1);
      begin
        for (int k = 0; k < 5000 && !rs485_de; k++)
          @(negedge ref_clk);
        check("reply start", {15'h0000, rs485_de}, 16'h0001);
        meas.temp_float = 32'hC1200000;
        meas.hum_float = 32'h3F800000;
      end
    join
    rd(8'hF5, 8'h03, 16'h012C, 8'h02, '{8'h09, 8'h19, 8'h13, 8'h88}, 1'b1);
    rd(8'hF5, 8'h04, 16'h0019, 8'h02, nil, 1'b0);
    wr(8'hF5, 16'h0019, 16'h0000, 1'b0);
    xact('{8'hF5, 8'h03, 8'h00, 8'h19, 8'h00, 8'h02}, nil, 1'b1);
    wr(8'hF5, 16'h0001, 16'h001D, 1'b0);
    load(SER);
    rd(8'hF5, 8'h03, 16'h0000, 8'h08, e, 1'b1);
    load(LBL);
    rd(8'hF5, 8'h04, 16'h0009, 8'h08, e, 1'b1);
    wr(8'hF5, 16'h0001, 16'h002D, 1'b1);
    master.par = 2'h1;
    master.two_stop = 1'b1;
    wr(8'hF5, 16'h0000, 16'h00F7, 1'b1);
    wr(8'hF7, 16'h0000, 16'h00F8, 1'b0);
    rd(8'hF5, 8'h04, 16'h0008, 8'h01, nil, 1'b0);
    rd(8'hF7, 8'h04, 16'h0008, 8'h01, '{8'h01, 8'h00}, 1'b1);
    wr(8'hF7, 16'h0001, 16'h0004, 1'b1);
    master.par = 2'h0;
    master.two_stop = 1'b0;
    master.bit_clks = TB_CLK_HZ / 76800;
    rd(8'hF7, 8'h03, 16'h012D, 8'h01, '{8'h13, 8'h88}, 1'b1);
    end_of_test();
  end
endmodule
